// *** core/dmo_pkg.sv ***
package dmo_pkg;
    // Region bases and geometry of the banked register areas
    localparam logic [15:0] PTR_BASE = 16'h0200;
    localparam logic [15:0] PTR_LAST = 16'h023f;
    localparam logic [15:0] LOC_BASE = 16'h0200;
    localparam logic [15:0] LOC_LAST = 16'h09ff;
    localparam logic [7:0] SFR_PAGE = 8'h00;
    localparam logic [7:0] FIX_PAGE = 8'h02;
    localparam int SET_SHIFT = 3;
    localparam logic [15:0] INC_WORD = 16'h0002;
    localparam logic [15:0] INC_BYTE = 16'h0001;
    // Position of the three-bit set select field in the status word
    localparam int SET_SEL_LSB = 0;

    typedef enum logic [1:0] {
        FMT_WORD,
        FMT_BYTE,
        FMT_BIT
    } dmo_fmt_t;

    typedef enum logic [3:0] {
        MODE_ACC,
        MODE_CTL,
        MODE_PTR,
        MODE_LOC,
        MODE_SFR,
        MODE_FIX,
        MODE_CUR,
        MODE_DIR,
        MODE_IND,
        MODE_IND_INC
    } dmo_mode_t;

    // Pointer register index, also its word slot within a set
    typedef enum logic [1:0] {
        PTR_INDEX_ONE,
        PTR_INDEX_TWO,
        PTR_DATA_POINTER,
        PTR_USER_STACK
    } dmo_ptr_t;

    typedef enum logic [2:0] {
        CTL_SYSTEM_STACK,
        CTL_LOCAL_BASE,
        CTL_STATUS_WORD,
        CTL_STATUS_HIGH,
        CTL_STATUS_LOW,
        CTL_CARRY
    } dmo_ctl_t;

    typedef enum logic [1:0] {
        TGT_MEM,
        TGT_ACC,
        TGT_CTL
    } dmo_tgt_t;
endpackage

// *** core/dmo_addr_gen.sv ***
`timescale 1ns/1ns
module dmo_addr_gen (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req,
    input wire dmo_pkg::dmo_mode_t req_mode,
    input wire dmo_pkg::dmo_fmt_t req_fmt,
    input wire logic [15:0] req_code,
    input wire logic [2:0] req_reg_field,
    input wire dmo_pkg::dmo_ptr_t req_ptr,
    input wire dmo_pkg::dmo_ctl_t req_ctl,
    input wire logic req_loop_jump,
    input wire logic req_sfr_own_word,
    input wire logic [15:0] status_word,
    input wire logic [15:0] local_base,
    output dmo_pkg::dmo_tgt_t opnd_target,
    output logic opnd_valid,
    output logic opnd_fault,
    output logic [15:0] opnd_addr,
    output logic opnd_acc_low,
    output dmo_pkg::dmo_ctl_t opnd_ctl,
    output logic busy,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PTR_RD,
        ST_PTR_WR
    } dmo_state_t;

    dmo_state_t state_q;
    dmo_pkg::dmo_tgt_t tgt_q;
    dmo_pkg::dmo_ctl_t ctl_q;
    logic valid_q, fault_q, acc_low_q, busy_q;
    logic [15:0] addr_q;
    logic mreq_q, mwe_q;
    logic [15:0] maddr_q, mwdata_q;
    logic word_q, inc_q, own_q;

    logic take;
    logic [2:0] set_sel;
    logic [15:0] ptr_slot;
    logic [15:0] raw_d;
    logic fault_d;
    logic skip_align;

    assign take = req && (state_q == ST_IDLE);
    assign set_sel = status_word[dmo_pkg::SET_SEL_LSB +: 3];
    // Pointer word slot: set base plus two bytes per pointer, low byte even
    assign ptr_slot = dmo_pkg::PTR_BASE + {10'h000, set_sel, 3'h0}
                      + {13'h0000, req_ptr, 1'b0};

    // Word operands stay where the register defines them for flagged special page regs
    assign skip_align = (req_mode == dmo_pkg::MODE_SFR) && req_sfr_own_word;

    always_comb begin
        raw_d = 16'h0000;
        fault_d = 1'b0;
        case (req_mode)
            dmo_pkg::MODE_PTR: begin
                raw_d = ptr_slot;
                if (req_fmt == dmo_pkg::FMT_BIT) begin
                    fault_d = 1'b1;
                end else if (req_fmt == dmo_pkg::FMT_BYTE && req_ptr == dmo_pkg::PTR_DATA_POINTER
                             && !req_loop_jump) begin
                    fault_d = 1'b1;
                end
            end
            dmo_pkg::MODE_LOC: begin
                if (req_fmt == dmo_pkg::FMT_WORD) begin
                    raw_d = dmo_pkg::LOC_BASE + {5'h00, local_base[7:0], 3'h0}
                            + {13'h0000, req_reg_field[1:0], 1'b0};
                end else begin
                    raw_d = dmo_pkg::LOC_BASE + {5'h00, local_base[7:0], 3'h0}
                            + {13'h0000, req_reg_field};
                end
            end
            dmo_pkg::MODE_SFR: raw_d = {dmo_pkg::SFR_PAGE, req_code[7:0]};
            dmo_pkg::MODE_FIX: raw_d = {dmo_pkg::FIX_PAGE, req_code[7:0]};
            dmo_pkg::MODE_CUR: raw_d = {local_base[15:8], req_code[7:0]};
            dmo_pkg::MODE_DIR: raw_d = req_code;
            dmo_pkg::MODE_CTL: begin
                case (req_ctl)
                    dmo_pkg::CTL_SYSTEM_STACK,
                    dmo_pkg::CTL_LOCAL_BASE,
                    dmo_pkg::CTL_STATUS_WORD: fault_d = (req_fmt != dmo_pkg::FMT_WORD);
                    dmo_pkg::CTL_STATUS_HIGH,
                    dmo_pkg::CTL_STATUS_LOW: fault_d = (req_fmt != dmo_pkg::FMT_BYTE);
                    dmo_pkg::CTL_CARRY: fault_d = (req_fmt != dmo_pkg::FMT_BIT);
                    default: fault_d = 1'b1;
                endcase
            end
            dmo_pkg::MODE_IND_INC: begin
                raw_d = dmo_pkg::PTR_BASE + {10'h000, set_sel, 3'h0}
                        + {13'h0000, dmo_pkg::PTR_DATA_POINTER, 1'b0};
            end
            dmo_pkg::MODE_IND: begin
                // Only the data pointer and index one may serve as plain indirect bases
                raw_d = ptr_slot;
                fault_d = (req_ptr != dmo_pkg::PTR_DATA_POINTER)
                          && (req_ptr != dmo_pkg::PTR_INDEX_ONE);
            end
            default: begin
                raw_d = 16'h0000;
                fault_d = 1'b0;
            end
        endcase
    end

    // Next even address for odd words; wraps FFFFH to zero
    function automatic logic [15:0] dmo_align(input logic [15:0] a, input logic word,
                                               input logic keep);
        dmo_align = (word && !keep) ? a + {15'h0000, a[0]} : a;
    endfunction

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take && !fault_d && (req_mode == dmo_pkg::MODE_IND
                                             || req_mode == dmo_pkg::MODE_IND_INC)) begin
                        state_q <= ST_PTR_RD;
                    end
                end
                ST_PTR_RD: begin
                    if (mem_ack) begin
                        state_q <= inc_q ? ST_PTR_WR : ST_IDLE;
                    end
                end
                ST_PTR_WR: begin
                    if (mem_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Operand result
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            fault_q <= 1'b0;
            addr_q <= 16'h0000;
            tgt_q <= dmo_pkg::TGT_MEM;
            ctl_q <= dmo_pkg::CTL_SYSTEM_STACK;
            acc_low_q <= 1'b0;
            word_q <= 1'b0;
            inc_q <= 1'b0;
            own_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (take) begin
                word_q <= (req_fmt == dmo_pkg::FMT_WORD);
                inc_q <= (req_mode == dmo_pkg::MODE_IND_INC);
                own_q <= skip_align;
                fault_q <= fault_d;
                ctl_q <= req_ctl;
                acc_low_q <= (req_fmt != dmo_pkg::FMT_WORD);
                tgt_q <= (req_mode == dmo_pkg::MODE_ACC) ? dmo_pkg::TGT_ACC :
                         (req_mode == dmo_pkg::MODE_CTL) ? dmo_pkg::TGT_CTL : dmo_pkg::TGT_MEM;
                addr_q <= dmo_align(raw_d, req_fmt == dmo_pkg::FMT_WORD, skip_align);
                // Indirect answers wait for the pointer read unless refused at once
                valid_q <= fault_d || !(req_mode == dmo_pkg::MODE_IND
                                        || req_mode == dmo_pkg::MODE_IND_INC);
            end else if (state_q == ST_PTR_RD && mem_ack) begin
                addr_q <= dmo_align(mem_rdata, word_q, 1'b0);
                valid_q <= 1'b1;
            end
        end
    end

    // Pointer fetch and write-back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mreq_q <= 1'b0;
            mwe_q <= 1'b0;
            maddr_q <= 16'h0000;
            mwdata_q <= 16'h0000;
        end else begin
            if (take && !fault_d && (req_mode == dmo_pkg::MODE_IND
                                     || req_mode == dmo_pkg::MODE_IND_INC)) begin
                mreq_q <= 1'b1;
                mwe_q <= 1'b0;
                maddr_q <= raw_d;
            end else if (state_q == ST_PTR_RD && mem_ack && inc_q) begin
                mwe_q <= 1'b1;
                // Plain 16-bit sum drops the carry out
                mwdata_q <= mem_rdata + (word_q ? dmo_pkg::INC_WORD
                                                : dmo_pkg::INC_BYTE);
            end else if (mem_ack) begin
                mreq_q <= 1'b0;
                mwe_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (take && !fault_d && (req_mode == dmo_pkg::MODE_IND
                                            || req_mode == dmo_pkg::MODE_IND_INC))
                      || (state_q == ST_PTR_RD && !(mem_ack && !inc_q))
                      || (state_q == ST_PTR_WR && !mem_ack);
        end
    end

    assign opnd_target = tgt_q;
    assign opnd_valid = valid_q;
    assign opnd_fault = fault_q;
    assign opnd_addr = addr_q;
    assign opnd_acc_low = acc_low_q;
    assign opnd_ctl = ctl_q;
    assign busy = busy_q;
    assign mem_req = mreq_q;
    assign mem_we = mwe_q;
    assign mem_addr = maddr_q;
    assign mem_wdata = mwdata_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    acc_width_a: assert property (take && req_mode == dmo_pkg::MODE_ACC |=>
        opnd_valid && opnd_target == dmo_pkg::TGT_ACC
        && opnd_acc_low == ($past(req_fmt) != dmo_pkg::FMT_WORD))
        else $error("accumulator width wrong");
    ctl_carry_a: assert property (take && req_mode == dmo_pkg::MODE_CTL
        && req_ctl == dmo_pkg::CTL_CARRY && req_fmt == dmo_pkg::FMT_BIT |=>
        opnd_valid && !opnd_fault && opnd_ctl == dmo_pkg::CTL_CARRY)
        else $error("carry bit operand refused");
    ptr_region_a: assert property (take && req_mode == dmo_pkg::MODE_PTR |=>
        opnd_fault || (opnd_addr >= dmo_pkg::PTR_BASE && opnd_addr <= dmo_pkg::PTR_LAST
        && opnd_addr[5:3] == $past(status_word[2:0])))
        else $error("pointer set address wrong");
    dpl_guard_a: assert property (take && req_mode == dmo_pkg::MODE_PTR
        && req_fmt == dmo_pkg::FMT_BYTE && req_ptr == dmo_pkg::PTR_DATA_POINTER
        && !req_loop_jump |=> opnd_valid && opnd_fault)
        else $error("data pointer low byte not refused");
    local_byte_a: assert property (take && req_mode == dmo_pkg::MODE_LOC
        && req_fmt == dmo_pkg::FMT_BYTE |=> opnd_addr == dmo_pkg::LOC_BASE
        + {5'h00, $past(local_base[7:0]), 3'h0} + {13'h0000, $past(req_reg_field)})
        else $error("local byte address wrong");
    fix_page_a: assert property (take && req_mode == dmo_pkg::MODE_FIX
        && req_fmt != dmo_pkg::FMT_WORD |=> opnd_addr == {dmo_pkg::FIX_PAGE, $past(req_code[7:0])})
        else $error("fixed page address wrong");
    cur_page_a: assert property (take && req_mode == dmo_pkg::MODE_CUR
        && req_fmt == dmo_pkg::FMT_BYTE |=> opnd_addr[15:8] == $past(local_base[15:8]))
        else $error("current page wrong");
    word_align_a: assert property (opnd_valid && !opnd_fault
        && opnd_target == dmo_pkg::TGT_MEM && word_q && !own_q |-> !opnd_addr[0])
        else $error("word operand left odd");
    post_inc_a: assert property (state_q == ST_PTR_RD && mem_ack && inc_q |=>
        mem_req && mem_we && mem_wdata == $past(mem_rdata)
        + ($past(word_q) ? dmo_pkg::INC_WORD : dmo_pkg::INC_BYTE))
        else $error("post increment value wrong");
    ind_addr_a: assert property (state_q == ST_PTR_RD && mem_ack && !word_q |=>
        opnd_valid && opnd_addr == $past(mem_rdata))
        else $error("indirect address not pointer contents");

    acc_op_c: cover property (take && req_mode == dmo_pkg::MODE_ACC);
    inc_done_c: cover property (state_q == ST_PTR_WR && mem_ack);
    fault_c: cover property (opnd_valid && opnd_fault);
    own_word_c: cover property (take && skip_align && req_code[0]);
endmodule

// *** testbench/dmo_mem_model.sv ***
`timescale 1ns/1ns
module dmo_mem_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] words [0:32767];
    logic [1:0] wait_q;
    logic hit;

    // Skip the edge of our own ack: the request fields are changing then
    assign hit = mem_req && !mem_ack && (wait_q == (slow ? 2'h3 : 2'h0));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_q <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            // Idle data toggles so a stale sample never looks valid
            mem_rdata <= ~mem_rdata;
            if (hit) begin
                mem_ack <= 1'b1;
                wait_q <= 2'h0;
                if (!mem_we) begin
                    mem_rdata <= words[mem_addr[15:1]];
                end
            end else if (mem_req && !mem_ack) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end

    // Plain process: the bench also preloads this array directly
    always @(posedge clk_sys) begin
        if (!rst && hit && mem_we) begin
            words[mem_addr[15:1]] <= mem_wdata;
        end
    end
endmodule

// *** testbench/data_memory_operand_addressing_test.sv ***
`timescale 1ns/1ns
module data_memory_operand_addressing_test;
    logic clk_sys, rst, req, req_loop_jump, req_sfr_own_word, slow, mem_ack;
    logic opnd_valid, opnd_fault, opnd_acc_low, busy, mem_req, mem_we;
    logic [15:0] req_code, status_word, local_base, mem_rdata, opnd_addr, mem_addr, mem_wdata;
    logic [2:0] req_reg_field;
    dmo_pkg::dmo_mode_t req_mode;
    dmo_pkg::dmo_fmt_t req_fmt;
    dmo_pkg::dmo_ptr_t req_ptr;
    dmo_pkg::dmo_ctl_t req_ctl, opnd_ctl;
    dmo_pkg::dmo_tgt_t opnd_target;
    int errors, checked, cycles;

    dmo_addr_gen dmo_addr_gen_inst (.clk_sys, .rst, .req, .req_mode, .req_fmt, .req_code,
        .req_reg_field, .req_ptr, .req_ctl, .req_loop_jump, .req_sfr_own_word, .status_word,
        .local_base, .opnd_target, .opnd_valid, .opnd_fault, .opnd_addr, .opnd_acc_low,
        .opnd_ctl, .busy, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    dmo_mem_model dmo_mem_model_inst (.clk_sys, .rst, .slow, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Ceiling well above the hundred or so cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic op(input dmo_pkg::dmo_mode_t m, input dmo_pkg::dmo_fmt_t f,
                      input logic [15:0] code, input logic [2:0] fld, input dmo_pkg::dmo_ptr_t p);
        int n;
        @(negedge clk_sys);
        req = 1'b1;
        req_mode = m;
        req_fmt = f;
        req_code = code;
        req_reg_field = fld;
        req_ptr = p;
        @(negedge clk_sys);
        req = 1'b0;
        n = 0;
        while (opnd_valid !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        cmp({15'h0, opnd_valid}, 16'h0001);
        if (m != dmo_pkg::MODE_IND && m != dmo_pkg::MODE_IND_INC)
            cmp(16'(n), 16'h0000);
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        cmp({15'h0, busy}, 16'h0000);
    endtask

    task automatic chk(input logic f, input logic [15:0] a);
        cmp({15'h0, opnd_fault}, {15'h0, f});
        if (!f)
            cmp(opnd_addr, a);
    endtask

    task automatic t_acc;
        op(dmo_pkg::MODE_ACC, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        cmp({14'h0, opnd_target}, {14'h0, dmo_pkg::TGT_ACC});
        cmp({15'h0, opnd_acc_low}, 16'h0000);
        op(dmo_pkg::MODE_ACC, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        cmp({15'h0, opnd_acc_low}, 16'h0001);
        op(dmo_pkg::MODE_ACC, dmo_pkg::FMT_BIT, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        cmp({15'h0, opnd_acc_low}, 16'h0001);
        $display("accumulator test done");
    endtask

    task automatic t_ctl;
        dmo_pkg::dmo_fmt_t f;
        for (int i = 0; i < 6; i++) begin
            req_ctl = dmo_pkg::dmo_ctl_t'(i);
            f = i < 3 ? dmo_pkg::FMT_WORD : (i < 5 ? dmo_pkg::FMT_BYTE : dmo_pkg::FMT_BIT);
            op(dmo_pkg::MODE_CTL, f, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
            cmp({15'h0, opnd_fault}, 16'h0000);
            cmp({13'h0, opnd_ctl}, 16'(i));
            cmp({14'h0, opnd_target}, {14'h0, dmo_pkg::TGT_CTL});
        end
        op(dmo_pkg::MODE_CTL, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b1, 16'h0000);
        $display("control test done");
    endtask

    task automatic t_ptr;
        status_word = 16'h8005;
        for (int p = 0; p < 4; p++) begin
            op(dmo_pkg::MODE_PTR, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::dmo_ptr_t'(p));
            chk(1'b0, 16'h0228 + 16'(2 * p));
        end
        op(dmo_pkg::MODE_PTR, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_USER_STACK);
        chk(1'b0, 16'h022e);
        op(dmo_pkg::MODE_PTR, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_DATA_POINTER);
        chk(1'b1, 16'h0000);
        req_loop_jump = 1'b1;
        op(dmo_pkg::MODE_PTR, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_DATA_POINTER);
        chk(1'b0, 16'h022c);
        req_loop_jump = 1'b0;
        op(dmo_pkg::MODE_PTR, dmo_pkg::FMT_BIT, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b1, 16'h0000);
        $display("pointer test done");
    endtask

    task automatic t_page;
        local_base = 16'h7aff;
        op(dmo_pkg::MODE_LOC, dmo_pkg::FMT_BYTE, 16'h0000, 3'h7, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h09ff);
        op(dmo_pkg::MODE_LOC, dmo_pkg::FMT_WORD, 16'h0000, 3'h7, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h09fe);
        op(dmo_pkg::MODE_SFR, dmo_pkg::FMT_BYTE, 16'h0035, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h0035);
        op(dmo_pkg::MODE_SFR, dmo_pkg::FMT_WORD, 16'h0035, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h0036);
        req_sfr_own_word = 1'b1;
        op(dmo_pkg::MODE_SFR, dmo_pkg::FMT_WORD, 16'h0035, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h0035);
        req_sfr_own_word = 1'b0;
        op(dmo_pkg::MODE_FIX, dmo_pkg::FMT_BIT, 16'h0080, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h0280);
        op(dmo_pkg::MODE_CUR, dmo_pkg::FMT_BYTE, 16'hee11, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h7a11);
        op(dmo_pkg::MODE_DIR, dmo_pkg::FMT_WORD, 16'hffff, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h0000);
        op(dmo_pkg::MODE_DIR, dmo_pkg::FMT_BIT, 16'h1235, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h1235);
        $display("page test done");
    endtask

    task automatic t_ind;
        status_word = 16'h0002;
        dmo_mem_model_inst.words[15'h010a] = 16'h4321;
        dmo_mem_model_inst.words[15'h0108] = 16'h5555;
        op(dmo_pkg::MODE_IND, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::PTR_DATA_POINTER);
        chk(1'b0, 16'h4322);
        op(dmo_pkg::MODE_IND, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_ONE);
        chk(1'b0, 16'h5555);
        op(dmo_pkg::MODE_IND, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::PTR_INDEX_TWO);
        chk(1'b1, 16'h0000);
        cmp({15'h0, mem_req}, 16'h0000);
        dmo_mem_model_inst.words[15'h010a] = 16'hffff;
        op(dmo_pkg::MODE_IND_INC, dmo_pkg::FMT_WORD, 16'h0000, 3'h0, dmo_pkg::PTR_DATA_POINTER);
        chk(1'b0, 16'h0000);
        cmp(dmo_mem_model_inst.words[15'h010a], 16'h0001);
        slow = 1'b1;
        dmo_mem_model_inst.words[15'h010a] = 16'h1000;
        op(dmo_pkg::MODE_IND_INC, dmo_pkg::FMT_BYTE, 16'h0000, 3'h0, dmo_pkg::PTR_DATA_POINTER);
        chk(1'b0, 16'h1000);
        cmp(dmo_mem_model_inst.words[15'h010a], 16'h1001);
        $display("indirect test done");
    endtask

    initial begin
        rst = 1'b1;
        req = 1'b0;
        req_mode = dmo_pkg::MODE_ACC;
        req_fmt = dmo_pkg::FMT_WORD;
        req_code = 16'h0000;
        req_reg_field = 3'h0;
        req_ptr = dmo_pkg::PTR_INDEX_ONE;
        req_ctl = dmo_pkg::CTL_SYSTEM_STACK;
        req_loop_jump = 1'b0;
        req_sfr_own_word = 1'b0;
        status_word = 16'h0000;
        local_base = 16'h0000;
        slow = 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_acc();
        t_ctl();
        t_ptr();
        t_page();
        t_ind();
        summarize();
    end
endmodule
